// File: hw/flash_pe_defines.svh
// Opcodes, address geometry and timing counts for the program/erase sequencer
`ifndef FLASH_PE_DEFINES_SVH
`define FLASH_PE_DEFINES_SVH

// Command opcodes
`define CMD_WRITE_ENABLE 8'h06
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_PAGE_PROGRAM_4B 8'h12
`define CMD_QUAD_PROGRAM 8'h32
`define CMD_QUAD_PROGRAM_4B 8'h34
`define CMD_SECTOR_ERASE 8'h20
`define CMD_SECTOR_ERASE_4B 8'h21
`define CMD_HALF_ERASE 8'h52
`define CMD_HALF_ERASE_4B 8'h53
`define CMD_BLOCK_ERASE 8'hd8
`define CMD_BLOCK_ERASE_4B 8'hdc

// Address geometry: region widths as log2 of the size in bytes, plus page size, address byte counts and erased value
`define ARRAY_ADDR_W 23
`define PAGE_AW 5'h08
`define SECTOR_AW 5'h0c
`define HALF_AW 5'h0f
`define BLOCK_AW 5'h10
`define PAGE_BYTES 256
`define ADDR_BYTES_SHORT 3'h3
`define ADDR_BYTES_LONG 3'h4
`define ERASED_BYTE 8'hff

// Timing
`define CLK_PERIOD_NS 20
`define QUAD_PROGRAM_MAX_MHZ 108
`define PAGE_PROGRAM_TIME_NS 400000
`define ERASE_TIME_NS 2000000
`define PAGE_PROGRAM_CYCLES (`PAGE_PROGRAM_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_CYCLES (`ERASE_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: hw/flash_pe_pkg.sv
// Types shared by the program/erase sequencer
package flash_pe_pkg;

  typedef struct packed {
    logic addr_4byte;
    logic quad_enable;
    logic four_line_command_mode;
  } cfg_s;

  typedef struct packed {
    logic busy_flag;
    logic write_enable_latch;
    logic program_error;
    logic erase_error;
  } status_s;

  typedef enum logic [2:0] {
    OP_PROGRAM = 3'h1,
    OP_SECTOR = 3'h2,
    OP_HALF = 3'h3,
    OP_BLOCK = 3'h4
  } op_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WALK = 2'h1,
    ST_WAIT = 2'h3
  } seq_state_e;

endpackage

// File: hw/spi_flash_program_erase_cmds.sv
// Program and erase command sequencer for a serial flash array
`timescale 1ns/10ps
`include "flash_pe_defines.svh"

module spi_flash_program_erase_cmds
  import flash_pe_pkg::*;
#(
  parameter int ADDR_W = `ARRAY_ADDR_W,
  parameter int PROG_CYCLES = `PAGE_PROGRAM_CYCLES,
  parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic chip_sel_n,
  input wire logic [3:0] io_in,
  input wire cfg_s cfg,
  input wire logic [(1 << (ADDR_W - 12)) - 1:0] sector_protect,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data,
  output status_s status
);

  localparam int SECTORS = 1 << (ADDR_W - 12);
  localparam int MEM_BYTES = 1 << ADDR_W;

  // Array size must fit the block geometry and the memory index
  if (ADDR_W < 16 || ADDR_W > 24 || PROG_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_bad_params
    $error("unsupported parameter values");
  end

  // True when any sector of the run is locked
  function automatic logic any_prot(input logic [SECTORS-1:0] map, input logic [ADDR_W-13:0] first,
                                    input logic [4:0] cnt);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i < int'(cnt) && map[int'(first) + i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ---------------- Link clock domain ----------------
  logic fresh_r;
  logic half_r;
  logic grp_tgl_r;
  logic [3:0] hold_r;
  logic [7:0] group_r;

  // Marks the first edge of a frame; the link clock is dead between frames
  always_ff @(posedge link_clk or posedge chip_sel_n or posedge reset) begin
    if (reset) begin
      fresh_r <= 1'b1;
    end else if (chip_sel_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // Two edges of four lanes form one group; a toggle hands it to the core
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      half_r <= 1'b0;
      hold_r <= 4'h0;
      group_r <= 8'h0;
      grp_tgl_r <= 1'b0;
    end else if (!chip_sel_n) begin
      if (fresh_r || !half_r) begin
        hold_r <= io_in;
        half_r <= 1'b1;
      end else begin
        group_r <= {hold_r, io_in};
        grp_tgl_r <= ~grp_tgl_r;
        half_r <= 1'b0;
      end
    end
  end

  // ---------------- Core clock domain ----------------
  logic [3:0] cs_sync_r;
  logic [2:0] tgl_sync_r;
  logic [1:0] half_sync_r;
  cfg_s cfg_m_r;
  cfg_s cfg_r;
  logic [SECTORS-1:0] prot_m_r;
  logic [SECTORS-1:0] prot_r;

  // Synchronisers; end of frame is seen one cycle after the last group
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cs_sync_r <= 4'hf;
      tgl_sync_r <= 3'h0;
      half_sync_r <= 2'h0;
      cfg_m_r <= '0;
      cfg_r <= '0;
      prot_m_r <= '0;
      prot_r <= '0;
    end else begin
      cs_sync_r <= {cs_sync_r[2:0], chip_sel_n};
      tgl_sync_r <= {tgl_sync_r[1:0], grp_tgl_r};
      half_sync_r <= {half_sync_r[0], half_r};
      cfg_m_r <= cfg;
      cfg_r <= cfg_m_r;
      prot_m_r <= sector_protect;
      prot_r <= prot_m_r;
    end
  end

  logic [7:0] opcode_r;
  logic [31:0] addr_r;
  logic [3:0] byte_idx_r;
  logic [8:0] data_cnt_r;
  logic [1:0] sgrp_r;
  logic [5:0] sbits_r;
  logic [255:0] loaded_r;
  logic [7:0] page_buf [0:`PAGE_BYTES-1];
  logic [7:0] mem [0:MEM_BYTES-1];
  seq_state_e state_r;
  seq_state_e state_nxt;
  op_kind_e op_kind_r;
  logic [ADDR_W-1:0] walk_ptr_r;
  logic [16:0] walk_left_r;
  logic [31:0] timer_r;
  logic [31:0] run_cnt_r;
  status_s status_r;
  logic [7:0] rd_data_r;

  // Opcode decode
  wire is_prog = opcode_r == `CMD_PAGE_PROGRAM || opcode_r == `CMD_PAGE_PROGRAM_4B;
  wire is_quad = opcode_r == `CMD_QUAD_PROGRAM || opcode_r == `CMD_QUAD_PROGRAM_4B;
  wire is_sect = opcode_r == `CMD_SECTOR_ERASE || opcode_r == `CMD_SECTOR_ERASE_4B;
  wire is_half = opcode_r == `CMD_HALF_ERASE || opcode_r == `CMD_HALF_ERASE_4B;
  wire is_block = opcode_r == `CMD_BLOCK_ERASE || opcode_r == `CMD_BLOCK_ERASE_4B;
  wire is_write_enable_cmd = opcode_r == `CMD_WRITE_ENABLE;
  wire op_long = opcode_r == `CMD_PAGE_PROGRAM_4B || opcode_r == `CMD_QUAD_PROGRAM_4B ||
                 opcode_r == `CMD_SECTOR_ERASE_4B || opcode_r == `CMD_HALF_ERASE_4B ||
                 opcode_r == `CMD_BLOCK_ERASE_4B;

  // Address length and lane width of the current byte
  wire [2:0] addr_bytes = (op_long || cfg_r.addr_4byte) ? `ADDR_BYTES_LONG : `ADDR_BYTES_SHORT;
  wire [3:0] hdr_bytes = {1'b0, addr_bytes} + 4'h1;
  wire in_data = byte_idx_r >= hdr_bytes;
  wire lanes4 = cfg_r.four_line_command_mode || (is_quad && in_data);
  wire idle = state_r == ST_IDLE;

  // Group and byte events; frames that arrive while busy are dropped
  wire grp_ev = tgl_sync_r[1] ^ tgl_sync_r[2];
  wire end_evt = cs_sync_r[2] && !cs_sync_r[3];
  wire byte_done = grp_ev && idle && (lanes4 || sgrp_r == 2'h3);
  wire [7:0] byte_val = lanes4 ? group_r : {sbits_r, group_r[4], group_r[0]};
  wire [7:0] buf_idx = addr_r[7:0] + data_cnt_r[7:0];

  // Frame checks at chip select rise
  wire whole = !half_sync_r[1] && (lanes4 || sgrp_r == 2'h0);
  wire prog_cmd = is_prog || (is_quad && cfg_r.quad_enable);
  wire prog_ok = end_evt && idle && whole && prog_cmd && data_cnt_r != 9'h0;
  wire erase_ok = end_evt && idle && whole && (is_sect || is_half || is_block) &&
                  byte_idx_r == hdr_bytes;
  wire write_enable_cmd_ok = end_evt && idle && whole && is_write_enable_cmd && byte_idx_r == 4'h1;
  wire want_op = (prog_ok || erase_ok) && status_r.write_enable_latch;

  // Target region and protection lookup
  wire [4:0] region_aw = is_sect ? `SECTOR_AW : is_half ? `HALF_AW : is_block ? `BLOCK_AW : `PAGE_AW;
  wire [ADDR_W-1:0] region_mask = {ADDR_W{1'b1}} << region_aw;
  wire [ADDR_W-1:0] base_w = addr_r[ADDR_W-1:0] & region_mask;
  wire [16:0] len_w = 17'h1 << region_aw;
  wire [4:0] sect_cnt = prog_ok ? 5'h01 : len_w[16:12];
  wire prot_hit = any_prot(prot_r, base_w[ADDR_W-1:12], sect_cnt);
  wire refuse = want_op && prot_hit;
  wire start = want_op && !prot_hit;
  wire op_done = state_r == ST_WAIT && timer_r == 32'h0;
  wire op_kind_e kind_w = prog_ok ? OP_PROGRAM : is_sect ? OP_SECTOR : is_half ? OP_HALF : OP_BLOCK;

  // Array write data: program ANDs the buffer in, erase writes ones
  wire [7:0] mem_old = mem[walk_ptr_r];
  wire [7:0] buf_byte = loaded_r[walk_ptr_r[7:0]] ? page_buf[walk_ptr_r[7:0]] : `ERASED_BYTE;
  wire [7:0] wr_data = (op_kind_r == OP_PROGRAM) ? (mem_old & buf_byte) : `ERASED_BYTE;
  wire walk_last = state_r == ST_WALK && walk_left_r == 17'h1;

  // Command assembly from group events
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      opcode_r <= 8'h0;
      addr_r <= 32'h0;
      byte_idx_r <= 4'h0;
      data_cnt_r <= 9'h0;
      sgrp_r <= 2'h0;
      sbits_r <= 6'h0;
    end else if (end_evt) begin
      opcode_r <= 8'h0;
      addr_r <= 32'h0;
      byte_idx_r <= 4'h0;
      data_cnt_r <= 9'h0;
      sgrp_r <= 2'h0;
      sbits_r <= 6'h0;
    end else if (grp_ev && idle) begin
      if (!lanes4) begin
        sgrp_r <= sgrp_r + 2'h1;
        sbits_r <= {sbits_r[3:0], group_r[4], group_r[0]};
      end
      if (byte_done) begin
        byte_idx_r <= (byte_idx_r == 4'hf) ? byte_idx_r : byte_idx_r + 4'h1;
        if (byte_idx_r == 4'h0) begin
          opcode_r <= byte_val;
        end else if (!in_data) begin
          addr_r <= {addr_r[23:0], byte_val};
        end else if (data_cnt_r != 9'h100) begin
          data_cnt_r <= data_cnt_r + 9'h1;
        end
      end
    end
  end

  // Page buffer; bytes past the page end wrap inside it; every byte after the 256th overwrites the first byte's slot
  always_ff @(posedge core_clk) begin
    if (byte_done && in_data && (is_prog || is_quad)) begin
      page_buf[buf_idx] <= byte_val;
    end
  end

  // Loaded-byte map, kept across the end of an accepted program
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      loaded_r <= 256'h0;
    end else if (byte_done && in_data && (is_prog || is_quad)) begin
      loaded_r[buf_idx] <= 1'b1;
    end else if ((end_evt && !(start && prog_ok)) || (walk_last && op_kind_r == OP_PROGRAM)) begin
      loaded_r <= 256'h0;
    end
  end

  // Sequencer: walk the region, then hold busy until the timer runs out
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_WALK;
        end
      end
      ST_WALK: begin
        if (walk_last) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (op_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      op_kind_r <= OP_PROGRAM;
      walk_ptr_r <= '0;
      walk_left_r <= 17'h0;
      timer_r <= 32'h0;
      run_cnt_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        op_kind_r <= kind_w;
        walk_ptr_r <= base_w;
        walk_left_r <= len_w;
        timer_r <= (prog_ok ? 32'(PROG_CYCLES) : 32'(ERASE_CYCLES));
        run_cnt_r <= 32'h0;
      end else begin
        if (state_r == ST_WALK) begin
          walk_ptr_r <= walk_ptr_r + 1'b1;
          walk_left_r <= walk_left_r - 17'h1;
        end
        if (!idle && timer_r != 32'h0) begin
          timer_r <= timer_r - 32'h1;
        end
        if (!idle) begin
          run_cnt_r <= run_cnt_r + 32'h1;
        end
      end
    end
  end

  // Array write port and read-back port
  always_ff @(posedge core_clk) begin
    if (state_r == ST_WALK) begin
      mem[walk_ptr_r] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data_r <= 8'h0;
    end else begin
      rd_data_r <= mem[rd_addr];
    end
  end

  // Status flags; latch drops at completion or on a protection refusal
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_r <= '0;
    end else begin
      status_r.busy_flag <= state_nxt != ST_IDLE;
      status_r.write_enable_latch <= write_enable_cmd_ok || (status_r.write_enable_latch && !op_done && !refuse);
      status_r.program_error <= (refuse && prog_ok) || (status_r.program_error && !start);
      status_r.erase_error <= (refuse && erase_ok) || (status_r.erase_error && !start);
    end
  end

  assign status = status_r;
  assign rd_data = rd_data_r;

  // ---------------- Checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_BUSY_WHILE_RUNNING: assert property (status_r.busy_flag == (state_r != ST_IDLE))
    else $error("busy flag disagrees with sequencer state");
  AST_START_NEEDS_LATCH: assert property (start |-> status_r.write_enable_latch && idle)
    else $error("operation started without write enable");
  AST_NO_LATCH_IGNORED: assert property ((end_evt && (prog_ok || erase_ok) && !status_r.write_enable_latch)
    |=> $stable(status_r.program_error) && $stable(status_r.erase_error) && state_r == ST_IDLE)
    else $error("command without write enable had an effect");
  AST_PARTIAL_DISCARD: assert property ((end_evt && idle && !whole) |=> state_r == ST_IDLE [*2])
    else $error("partial byte frame was executed");
  AST_QUAD_NEEDS_ENABLE: assert property ((start && is_quad) |-> cfg_r.quad_enable)
    else $error("quad program accepted with quad disabled");
  AST_PROT_ERASE_ERR: assert property ((erase_ok && status_r.write_enable_latch && prot_hit)
    |=> status_r.erase_error && !status_r.busy_flag && !status_r.write_enable_latch)
    else $error("protected erase not refused");
  AST_PROT_PROG_ERR: assert property ((prog_ok && status_r.write_enable_latch && prot_hit)
    |=> status_r.program_error && !status_r.busy_flag)
    else $error("protected program not refused");
  AST_ERASE_WRITES_ONES: assert property ((state_r == ST_WALK && op_kind_r != OP_PROGRAM)
    |-> wr_data == `ERASED_BYTE)
    else $error("erase wrote a zero bit");
  AST_PROGRAM_CLEARS_ONLY: assert property ((state_r == ST_WALK && op_kind_r == OP_PROGRAM)
    |-> (wr_data & ~mem_old) == 8'h0)
    else $error("program set a bit to one");
  AST_TIMED_LENGTH: assert property ((op_done && op_kind_r == OP_PROGRAM) |-> run_cnt_r >= PROG_CYCLES)
    else $error("program ended before its time");
  AST_HALF_SELECT: assert property ((start && is_half)
    |-> base_w[15] == addr_r[15] && base_w[14:0] == 15'h0 ##1 walk_left_r == 17'h8000)
    else $error("half block region wrong");

  COV_PROGRAM: cover property (start && prog_ok ##1 state_r == ST_WALK);
  COV_ERASE: cover property (start && is_block);
  COV_REFUSED: cover property (refuse && erase_ok);
  COV_PARTIAL: cover property (end_evt && idle && !whole && is_prog);

endmodule

// File: sim/flash_host_model.sv
// Host-side serial controller model that shifts command frames into the sequencer
`timescale 1ns/10ps
module flash_host_model (
  output logic link_clk,
  output logic chip_sel_n,
  output logic [3:0] io_in
);
  logic [7:0] fbuf [0:15];
  logic [3:0] grp [$];
  int fn;

  // Idle: select high, clock parked low
  initial begin
    link_clk = 1'b0;
    chip_sel_n = 1'b1;
    io_in = 4'h0;
    fn = 0;
  end

  // Queue one byte for the next frame
  task automatic put(input logic [7:0] b);
    fbuf[fn] = b;
    fn++;
  endtask

  // One 48 ns clock; data changes only after the falling edge
  task automatic edge_out(input logic [3:0] v);
    io_in = v;
    #24 link_clk = 1'b1;
    #24 link_clk = 1'b0;
  endtask

  // Bytes from index qf on go four bits a clock; drop cuts trailing edges
  task automatic frame(input int qf, input int drop);
    grp = {};
    for (int i = 0; i < fn; i++) begin
      if (i >= qf) begin
        grp.push_back(fbuf[i][7:4]);
        grp.push_back(fbuf[i][3:0]);
      end else begin
        for (int j = 7; j >= 0; j--) grp.push_back({{3{~fbuf[i][j]}}, fbuf[i][j]});
      end
    end
    chip_sel_n = 1'b0;
    for (int k = 0; k < grp.size() - drop; k++) edge_out(grp[k]);
    #24 chip_sel_n = 1'b1;
    io_in = ~io_in; // Released lines must not hold the last value
    fn = 0;
    #100;
  endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the program and erase sequencer
`timescale 1ns/10ps
module tb_top
  import flash_pe_pkg::*;
;
  logic core_clk;
  logic reset;
  logic link_clk;
  logic chip_sel_n;
  logic [3:0] io_in;
  cfg_s cfg;
  logic [31:0] sector_protect;
  logic [16:0] rd_addr;
  logic [7:0] rd_data;
  status_s status;
  status_s exp_st;
  int err_count;
  int checked;
  int lane_q;
  logic [7:0] eop [4] = '{8'h21, 8'h52, 8'hd8, 8'hdc};
  logic [31:0] eadr [4] = '{32'h4000, 32'h0, 32'h0, 32'h0};
  int elen [4] = '{4, 3, 3, 4};

  // Short counts keep erase and program runs small
  spi_flash_program_erase_cmds #(.ADDR_W(17), .PROG_CYCLES(40), .ERASE_CYCLES(60)) i_dut (
    .core_clk(core_clk),
    .reset(reset),
    .link_clk(link_clk),
    .chip_sel_n(chip_sel_n),
    .io_in(io_in),
    .cfg(cfg),
    .sector_protect(sector_protect),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .status(status)
  );

  flash_host_model i_host (
    .link_clk(link_clk),
    .chip_sel_n(chip_sel_n),
    .io_in(io_in)
  );

  // Core clock, 20 ns
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read-back is registered: value lands one edge after the address
  task automatic rd(input logic [16:0] a, input logic [7:0] exp);
    tick();
    rd_addr = a;
    tick();
    tick();
    check("rd_data", exp, rd_data);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int alen);
    i_host.put(op);
    for (int i = alen - 1; i >= 0; i--) i_host.put(a[8*i +: 8]);
  endtask

  // Mode 0 ignored, 1 accepted, 2 program error, 3 erase error, 4 write enable
  task automatic xfer(input int qf, input int drop, input int mode);
    int n;
    i_host.frame(qf, drop);
    n = 0;
    if (mode == 1) begin
      while (status.busy_flag !== 1'b1 && n < 12) begin
        tick();
        n++;
      end
      check("busy_flag rise", 8'h1, {7'h0, status.busy_flag});
      n = 0;
      while (status.busy_flag !== 1'b0 && n < 70000) begin
        tick();
        n++;
      end
      exp_st = '0;
    end else begin
      repeat (12) tick();
      // A refusal drops the latch; an earlier error stays until a start
      if (mode == 2 || mode == 3) exp_st.write_enable_latch = 1'b0;
      if (mode == 2) exp_st.program_error = 1'b1;
      if (mode == 3) exp_st.erase_error = 1'b1;
      if (mode == 4) exp_st.write_enable_latch = 1'b1;
    end
    check("status", {4'h0, exp_st}, {4'h0, status});
  endtask

  task automatic write_enable_cmd();
    i_host.put(8'h06);
    xfer(lane_q, 0, 4);
  endtask

  task automatic prog(input logic [7:0] op, input logic [31:0] a, input int alen, input int qf,
                      input logic [7:0] d0, input logic [7:0] d1, input int n, input int mode);
    write_enable_cmd();
    cmd(op, a, alen);
    if (n > 0) i_host.put(d0);
    if (n > 1) i_host.put(d1);
    xfer(qf, 0, mode);
  endtask

  // Hang guard, about twice the expected run
  initial begin
    #2000000;
    err_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    report_and_stop();
  end

  // Main sequence; sector 4 stays locked until the final unlock
  initial begin
    err_count = 0;
    checked = 0;
    lane_q = 99;
    reset = 1'b1;
    cfg = '0;
    sector_protect = 32'h0000_0010;
    rd_addr = '0;
    exp_st = '0;
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (5) tick();
    check("status after reset", 8'h0, {4'h0, status});
    cmd(8'h20, 32'h0, 3);
    xfer(99, 0, 0);
    prog(8'h20, 32'h0, 3, 99, 8'h0, 8'h0, 0, 1);
    rd(17'h00000, 8'hff);
    rd(17'h00fff, 8'hff);
    prog(8'h02, 32'h10, 3, 99, 8'h5a, 8'h3c, 2, 1);
    rd(17'h00010, 8'h5a);
    rd(17'h00011, 8'h3c);
    prog(8'h02, 32'h10, 3, 99, 8'hf0, 8'h0, 1, 1);
    rd(17'h00010, 8'h50);
    prog(8'h02, 32'hff, 3, 99, 8'h11, 8'h22, 2, 1);
    rd(17'h000ff, 8'h11);
    rd(17'h00000, 8'h22);
    // Final byte cut short, then an erase with a trailing byte
    write_enable_cmd();
    cmd(8'h02, 32'h20, 3);
    i_host.put(8'h77);
    xfer(99, 3, 0);
    rd(17'h00020, 8'hff);
    cmd(8'h20, 32'h0, 3);
    i_host.put(8'h00);
    xfer(99, 0, 0);
    rd(17'h00010, 8'h50);
    prog(8'h12, 32'h30, 4, 99, 8'ha5, 8'h0, 1, 1);
    rd(17'h00030, 8'ha5);
    cfg.addr_4byte = 1'b1;
    prog(8'h02, 32'h40, 4, 99, 8'h66, 8'h0, 1, 1);
    rd(17'h00040, 8'h66);
    cfg.addr_4byte = 1'b0;
    // Quad program refused until quad enable is set
    prog(8'h32, 32'h50, 3, 4, 8'hc3, 8'h0, 1, 0);
    rd(17'h00050, 8'hff);
    cfg.quad_enable = 1'b1;
    prog(8'h32, 32'h50, 3, 4, 8'hc3, 8'h0, 1, 1);
    rd(17'h00050, 8'hc3);
    prog(8'h34, 32'h51, 4, 5, 8'h3c, 8'h0, 1, 1);
    rd(17'h00051, 8'h3c);
    cfg.four_line_command_mode = 1'b1;
    lane_q = 0;
    prog(8'h02, 32'h60, 3, 0, 8'h99, 8'h0, 1, 1);
    rd(17'h00060, 8'h99);
    cfg.four_line_command_mode = 1'b0;
    lane_q = 99;
    // Locked sector: program and every covering erase refused
    prog(8'h02, 32'h4000, 3, 99, 8'h00, 8'h0, 1, 2);
    foreach (eop[i]) prog(eop[i], eadr[i], elen[i], 99, 8'h0, 8'h0, 0, 3);
    prog(8'h53, 32'h8000, 4, 99, 8'h0, 8'h0, 0, 1);
    rd(17'h08000, 8'hff);
    rd(17'h0ffff, 8'hff);
    rd(17'h00010, 8'h50);
    // Unlocked, the same sector erases normally
    sector_protect = 32'h0000_0000;
    prog(8'h20, 32'h4000, 3, 99, 8'h0, 8'h0, 0, 1);
    rd(17'h04000, 8'hff);
    report_and_stop();
  end
endmodule
